// ---- ccb_arm.sv ----
/*
  Re-arm detector: fires once on an accepted non-zero write, then needs
  an accepted zero write before it can fire again.
  Assumes the single pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module ccb_arm (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Accepted writes
  input  wire logic wr_set,
  input  wire logic wr_zero,
  // One-cycle start
  output logic      fire
);
  logic armed_reg;

  // A value left set never fires twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b1;
    end else if (wr_zero) begin
      armed_reg <= 1'b1;
    end else if (wr_set) begin
      armed_reg <= 1'b0;
    end
  end

  assign fire = wr_set & armed_reg;
endmodule : ccb_arm
`default_nettype wire

// ---- ccb_ctrl.sv ----
/*
  Connection control bits with the connection manager state and the link
  confidence test, behind an APB slave.
  Assumes signaling events and received line state arrive synchronous to pclk.
*/
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ccb_ctrl (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Signaling side
  input  wire logic        signaling_active_flag,
  input  wire logic        ev_to_next,
  input  wire logic        ev_join_done,
  input  wire logic        ev_stop,
  input  wire ccb_pkg::ccb_ls_e rx_line_state,
  // Transmit side
  output var ccb_pkg::ccb_ls_e tx_line_state,
  output logic             phy_data_request,
  output logic             remote_loop_en,
  output logic             station_bypass,
  output var ccb_pkg::ccb_state_e cm_state,
  output logic             lct_active
);
  import ccb_pkg::*;

  ccb_ctrl_s  ctrl_reg;
  logic [2:0] ctrl_a_reg;
  logic [15:0] len_reg;
  logic [15:0] lct_cnt_reg;
  logic       lct_run_reg;
  ccb_state_e state_reg;
  ccb_state_e state_next;
  ccb_ctrl_s  wr_b;
  logic       wr_en;
  logic       wr_ctrl_b;
  logic       in_next_ok;
  logic       loop_set;
  logic       loop_zero;
  logic       join_set;
  logic       join_zero;
  logic       loop_fire;
  logic       join_fire;
  logic       sig_cmd;
  logic       tick;
  logic       lct_end;
  logic       rx_sig;
  logic       addr_ok;
  logic [1:0] force_cmd;

  ////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, prdata captured in setup
  assign pready    = 1'b1;
  assign addr_ok   = (paddr == CTRL_B_OFS) || (paddr == CTRL_A_OFS) ||
                     (paddr == LEN_OFS) || (paddr == STAT_OFS);
  assign pslverr   = psel & penable & ~addr_ok;
  assign wr_en     = psel & penable & pwrite & addr_ok;
  assign wr_ctrl_b = wr_en & (paddr == CTRL_B_OFS);
  assign wr_b      = ccb_ctrl_s'(pwdata[15:0]);
  assign sig_cmd   = wr_en & (paddr == CTRL_A_OFS) & pwdata[CA_SIGNAL];
  assign force_cmd = wr_ctrl_b ? wr_b.force_cmd : FORCE_NONE;

  // Read data register; unmapped reads give zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      case (paddr)
        CTRL_B_OFS: prdata <= {16'h0000, ctrl_reg.rsvd, ctrl_reg.mls, ctrl_reg.class_s,
                               ctrl_reg.loop, ctrl_reg.join_req, ctrl_reg.long_t,
                               ctrl_reg.maint, FORCE_NONE};
        CTRL_A_OFS: prdata <= {30'h0, ctrl_a_reg[1:0]};
        LEN_OFS:    prdata <= {16'h0000, len_reg};
        STAT_OFS:   prdata <= {24'h00_0000, tx_line_state, station_bypass,
                               lct_run_reg, state_reg};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write qualification against the current state
  assign in_next_ok = (state_reg == ST_NEXT) & ~signaling_active_flag;
  // Clearing is always taken so the re-arm can never be locked out
  assign loop_zero  = wr_ctrl_b & (wr_b.loop == LOOP_NONE);
  assign loop_set   = wr_ctrl_b & (wr_b.loop != LOOP_NONE) & in_next_ok;
  assign join_zero  = wr_ctrl_b & ~wr_b.join_req;
  assign join_set   = wr_ctrl_b & wr_b.join_req & in_next_ok;

  // Control bits; force command is a strobe and never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ccb_ctrl_s'(CTRL_B_RST);
    end else if (wr_ctrl_b) begin
      ctrl_reg.mls    <= wr_b.mls;
      ctrl_reg.long_t <= wr_b.long_t;
      ctrl_reg.maint  <= wr_b.maint;
      if (state_reg == ST_OFF) begin
        ctrl_reg.class_s <= wr_b.class_s;
      end
      if (loop_zero | loop_set) begin
        ctrl_reg.loop <= wr_b.loop;
      end
      if (join_zero | join_set) begin
        ctrl_reg.join_req <= wr_b.join_req;
      end
    end
  end

  // Control_a scrub and bypass bits, test length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg <= CTRL_A_RST;
      len_reg    <= LEN_RST;
    end else if (wr_en) begin
      if (paddr == CTRL_A_OFS) begin
        ctrl_a_reg <= {1'b0, pwdata[CA_BYPASS], pwdata[CA_SCRUB]};
      end
      if (paddr == LEN_OFS) begin
        len_reg <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fresh-write detectors for test start and join
  ccb_arm u_loop_arm (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_set  (loop_set),
    .wr_zero (loop_zero),
    .fire    (loop_fire)
  );

  ccb_arm u_join_arm (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_set  (join_set),
    .wr_zero (join_zero),
    .fire    (join_fire)
  );

  ccb_tick #(.CYC(TICK_CYC)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Connection manager next state; force beats events
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:    if (ctrl_reg.maint) state_next = ST_MAINT;
      ST_BREAK:  if (ev_to_next) state_next = ST_NEXT;
      ST_NEXT:   if (join_fire) state_next = ST_JOIN;
      ST_JOIN:   if (ev_join_done) state_next = ST_ACTIVE;
      ST_MAINT:  if (!ctrl_reg.maint) state_next = ST_OFF;
      default:   state_next = state_reg;
    endcase
    if (ev_stop && state_reg != ST_MAINT) begin
      state_next = ST_OFF;
    end
    case (force_cmd)
      FORCE_BREAK: state_next = ST_BREAK;
      FORCE_TRACE: if (state_reg == ST_ACTIVE) state_next = ST_TRACE;
      FORCE_OFF:   state_next = ST_OFF;
      default:     ;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link confidence test
  assign rx_sig  = (rx_line_state == LS_MASTER) | (rx_line_state == LS_HALT);
  assign lct_end = rx_sig
                 | join_fire
                 | sig_cmd
                 | loop_zero
                 | (state_next != ST_NEXT)
                 | (~ctrl_reg.long_t & tick & (lct_cnt_reg == 16'h0000));

  // Start needs a fresh non-zero loop value while in NEXT
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lct_run_reg <= 1'b0;
      lct_cnt_reg <= 16'h0000;
    end else if (lct_run_reg && lct_end) begin
      lct_run_reg <= 1'b0;
    end else if (loop_fire && state_next == ST_NEXT) begin
      lct_run_reg <= 1'b1;
      lct_cnt_reg <= len_reg;
    end else if (lct_run_reg && tick && lct_cnt_reg != 16'h0000) begin
      lct_cnt_reg <= lct_cnt_reg - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit selection
  always_comb begin
    tx_line_state    = LS_IDLE;
    phy_data_request = 1'b0;
    remote_loop_en   = 1'b0;
    if (state_reg == ST_MAINT) begin
      case (ctrl_reg.mls)
        3'h1:    tx_line_state = LS_IDLE;
        3'h2:    tx_line_state = LS_HALT;
        3'h3:    tx_line_state = LS_MASTER;
        3'h6:    tx_line_state = LS_DATA;
        default: tx_line_state = LS_QUIET;
      endcase
      phy_data_request = (ctrl_reg.mls == 3'h6);
    end else if (lct_run_reg) begin
      case (ctrl_reg.loop)
        LOOP_DATA:   tx_line_state = LS_DATA;
        LOOP_REMOTE: tx_line_state = LS_DATA;
        default:     tx_line_state = LS_IDLE;
      endcase
      phy_data_request = (ctrl_reg.loop != LOOP_IDLE);
      remote_loop_en   = (ctrl_reg.loop == LOOP_REMOTE);
    end else if (state_reg == ST_OFF || state_reg == ST_BREAK) begin
      tx_line_state = LS_QUIET;
    end
  end

  // Bypass: class bit only outside MAINT
  always_comb begin
    if (state_reg == ST_MAINT) begin
      station_bypass = ctrl_a_reg[CA_SCRUB] | ctrl_a_reg[CA_BYPASS];
    end else if (ctrl_reg.class_s) begin
      station_bypass = 1'b0;
    end else begin
      station_bypass = (state_reg != ST_ACTIVE);
    end
  end

  assign cm_state   = state_reg;
  assign lct_active = lct_run_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence join_fresh_s;
    join_fire && state_reg == ST_NEXT && force_cmd == FORCE_NONE && !ev_stop;
  endsequence

  class_lock_a: assert property (
    (wr_ctrl_b && state_reg != ST_OFF) |=> $stable(ctrl_reg.class_s))
    else $error("class bit changed outside OFF");
  class_bypass_a: assert property (
    (ctrl_reg.class_s && state_reg != ST_MAINT) |-> !station_bypass)
    else $error("single-attach station bypassed");
  maint_bypass_a: assert property (
    state_reg == ST_MAINT |-> station_bypass == (ctrl_a_reg[0] | ctrl_a_reg[1]))
    else $error("maintenance bypass wrong");
  lct_next_a: assert property (
    lct_run_reg |-> state_reg == ST_NEXT && ctrl_reg.loop != LOOP_NONE)
    else $error("test running outside NEXT");
  loop_remote_a: assert property (
    (lct_run_reg && ctrl_reg.loop == LOOP_REMOTE && state_reg != ST_MAINT)
      |-> phy_data_request && remote_loop_en)
    else $error("remote loop not driven");
  join_go_a: assert property (
    join_fresh_s |=> state_reg == ST_JOIN && !lct_run_reg)
    else $error("join request not taken");
  retrig_block_a: assert property (
    (loop_set && ctrl_reg.loop != LOOP_NONE) |-> !loop_fire)
    else $error("test retriggered without clear");
  maint_go_a: assert property (
    (state_reg == ST_OFF && ctrl_reg.maint && force_cmd == FORCE_NONE && !ev_stop)
      |=> state_reg == ST_MAINT)
    else $error("maintenance entry missed");
  force_break_a: assert property (
    force_cmd == FORCE_BREAK |=> state_reg == ST_BREAK)
    else $error("force to BREAK missed");
  lct_halt_a: assert property (
    (lct_run_reg && rx_sig) |=> !lct_run_reg)
    else $error("test not stopped by neighbour");
endmodule : ccb_ctrl
`default_nettype wire

// ---- ccb_nbr.sv ----
/*
  Behavioural neighbour station facing the connection control bits.
  Assumes the single pclk domain; the bench says when to resume signaling.
*/
`timescale 1ns/100ps
`default_nettype none
module ccb_nbr (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Local transmit and bench control
  input  wire ccb_pkg::ccb_ls_e tx_line_state,
  input  wire logic        send_master,
  // Line state seen by the local station
  output var ccb_pkg::ccb_ls_e rx_line_state
);
  import ccb_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Mirror Quiet, else Idle; Master once signaling resumes, one edge late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_line_state <= LS_QUIET;
    end else if (send_master) begin
      rx_line_state <= LS_MASTER;
    end else begin
      rx_line_state <= (tx_line_state == LS_QUIET) ? LS_QUIET : LS_IDLE;
    end
  end
endmodule : ccb_nbr
`default_nettype wire

// ---- ccb_pkg.sv ----
/*
  Constants, field layout and state encodings of the connection control bits.
  Assumes a 125 MHz pclk and a 32-bit APB register port.
*/
package ccb_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_B_OFS = 8'h00;
  localparam logic [7:0] CTRL_A_OFS = 8'h04;
  localparam logic [7:0] LEN_OFS    = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0C;
  // Reset values
  localparam logic [15:0] CTRL_B_RST = 16'h0000;
  localparam logic [2:0]  CTRL_A_RST = 3'h0;
  localparam logic [15:0] LEN_RST    = 16'h0064;
  // Loopback selections
  localparam logic [1:0] LOOP_NONE   = 2'h0;
  localparam logic [1:0] LOOP_DATA   = 2'h1;
  localparam logic [1:0] LOOP_IDLE   = 2'h2;
  localparam logic [1:0] LOOP_REMOTE = 2'h3;
  // Forced-state commands
  localparam logic [1:0] FORCE_NONE  = 2'h0;
  localparam logic [1:0] FORCE_BREAK = 2'h1;
  localparam logic [1:0] FORCE_TRACE = 2'h2;
  localparam logic [1:0] FORCE_OFF   = 2'h3;
  // Control_a bit positions
  localparam int CA_SCRUB  = 0;
  localparam int CA_BYPASS = 1;
  localparam int CA_SIGNAL = 2;
  // Test length unit: one microsecond per count
  localparam int CLK_NS   = 8;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  // Connection manager states
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_BREAK  = 3'b001,
    ST_NEXT   = 3'b010,
    ST_JOIN   = 3'b011,
    ST_ACTIVE = 3'b100,
    ST_TRACE  = 3'b101,
    ST_MAINT  = 3'b110
  } ccb_state_e;

  // Line states; codes match the maintenance field
  typedef enum logic [2:0] {
    LS_QUIET  = 3'b000,
    LS_IDLE   = 3'b001,
    LS_HALT   = 3'b010,
    LS_MASTER = 3'b011,
    LS_DATA   = 3'b110
  } ccb_ls_e;

  // Layout of connection_control_b
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] mls;
    logic       class_s;
    logic [1:0] loop;
    logic       join_req;
    logic       long_t;
    logic       maint;
    logic [1:0] force_cmd;
  } ccb_ctrl_s;
endpackage : ccb_pkg

// ---- ccb_tick.sv ----
/*
  Free-running divider giving a one-cycle enable per test length unit.
  Assumes the single pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module ccb_tick #(
  parameter int CYC = 125
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Enable out
  output logic      tick
);
  logic [7:0] cnt_reg;

  // Wraps every CYC cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (tick) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  assign tick = (cnt_reg == 8'(CYC - 1));
endmodule : ccb_tick
`default_nettype wire

// ---- tb_connection_mgmt_ctrl_bits.sv ----
/*
  Self-checking bench for the connection control bits over APB.
  Assumes ccb_ctrl with zero wait states and the ccb_nbr neighbour model.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_connection_mgmt_ctrl_bits;
  import ccb_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        sig_flag, ev_to_next, ev_join_done, ev_stop, send_master;
  logic        phy_data_request, remote_loop_en, station_bypass, lct_active;
  ccb_ls_e     rx_ls, tx_ls;
  ccb_state_e  cm_state;
  int          failures, num_checks, cyc, n, l, m;

  ccb_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .signaling_active_flag(sig_flag), .ev_to_next(ev_to_next),
    .ev_join_done(ev_join_done), .ev_stop(ev_stop), .rx_line_state(rx_ls),
    .tx_line_state(tx_ls), .phy_data_request(phy_data_request),
    .remote_loop_en(remote_loop_en), .station_bypass(station_bypass),
    .cm_state(cm_state), .lct_active(lct_active));
  ccb_nbr i_nbr (.pclk(pclk), .presetn(presetn), .tx_line_state(tx_ls),
    .send_master(send_master), .rx_line_state(rx_ls));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask : rd
  // Two-edge event pulse: 0 to next, 1 join done, 2 stop
  task automatic pulse(input int k);
    @(posedge pclk);
    ev_to_next <= (k == 0); ev_join_done <= (k == 1); ev_stop <= (k == 2);
    @(posedge pclk);
    ev_to_next <= 1'b0; ev_join_done <= 1'b0; ev_stop <= 1'b0;
    #1;
  endtask : pulse
  task automatic wait_lct(input logic e, input int mx);
    n = 0;
    while (lct_active !== e && n < mx) begin
      @(posedge pclk);
      #1;
      n++;
    end
    #1;
  endtask : wait_lct
  task automatic results();
    $display("Checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, sig_flag, ev_to_next, ev_join_done, ev_stop, send_master} = '0;
    paddr = 8'h00; pwdata = 32'h0000_0000; cyc = 0; presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_B_OFS, {16'h0000, CTRL_B_RST});
    rd(LEN_OFS, {16'h0000, LEN_RST});
    rd(STAT_OFS, 32'h0000_0010);
    rd(8'h10, 32'h0000_0000);
    chk(perr, 1'b1);
    chk(pready, 1'b1);
    $display("Test reset done");
    // Maintenance line state codes, then leave by clearing the request
    for (m = 0; m < 8; m++) begin
      wr(CTRL_B_OFS, (m << 8) | 32'h4);
      @(posedge pclk);
      #1;
      chk(cm_state, ST_MAINT);
      chk(tx_ls, (m < 4 || m == 6) ? m : 0);
      chk(phy_data_request, m == 6);
    end
    wr(CTRL_B_OFS, 32'h0000_0000);
    @(posedge pclk);
    #1;
    chk(cm_state, ST_OFF);
    $display("Test maint done");
    // Class set in OFF only; force to BREAK keeps station in
    wr(CTRL_B_OFS, 32'h80);
    rd(CTRL_B_OFS, 32'h80);
    wr(CTRL_B_OFS, 32'h81);
    chk(cm_state, ST_BREAK);
    chk(station_bypass, 1'b0);
    wr(CTRL_B_OFS, 32'h00);
    rd(CTRL_B_OFS, 32'h80);
    pulse(0);
    chk(cm_state, ST_NEXT);
    // Writes refused while signaling
    @(posedge pclk) sig_flag <= 1'b1;
    wr(CTRL_B_OFS, 32'h90);
    chk(cm_state, ST_NEXT);
    wr(CTRL_B_OFS, 32'hA0);
    chk(lct_active, 1'b0);
    rd(CTRL_B_OFS, 32'h80);
    @(posedge pclk) sig_flag <= 1'b0;
    $display("Test class done");
    // Every loopback, stop on Master, no retrigger on unchanged value
    for (l = 1; l < 4; l++) begin
      wr(CTRL_B_OFS, 32'h80 | (l << 5));
      chk(lct_active, 1'b1);
      chk(phy_data_request, l[0]);
      chk(remote_loop_en, l == 3);
      chk(tx_ls, (l == 2) ? LS_IDLE : LS_DATA);
      @(posedge pclk) send_master <= 1'b1;
      wait_lct(1'b0, 4);
      @(posedge pclk) send_master <= 1'b0;
      chk(n < 4, 1'b1);
      wr(CTRL_B_OFS, 32'h80 | (l << 5));
      chk(lct_active, 1'b0);
      wr(CTRL_B_OFS, 32'h80);
    end
    $display("Test loop done");
    // Join aborts a running test; a bit left set does not join again
    wr(CTRL_B_OFS, 32'hA0);
    chk(lct_active, 1'b1);
    wr(CTRL_B_OFS, 32'hB0);
    chk(cm_state, ST_JOIN);
    chk(lct_active, 1'b0);
    pulse(1);
    wr(CTRL_B_OFS, 32'hB2);
    chk(cm_state, ST_TRACE);
    wr(CTRL_B_OFS, 32'hB1);
    pulse(0);
    repeat (2) @(posedge pclk);
    #1;
    chk(cm_state, ST_NEXT);
    wr(CTRL_B_OFS, 32'h80);
    wr(CTRL_B_OFS, 32'h90);
    chk(cm_state, ST_JOIN);
    $display("Test join done");
    // Programmed length of two units, then extended test
    wr(CTRL_B_OFS, 32'h81);
    pulse(0);
    wr(LEN_OFS, 32'h2);
    wr(CTRL_B_OFS, 32'hA0);
    wait_lct(1'b0, 5 * TICK_CYC);
    chk(n >= 2 * TICK_CYC && n <= 4 * TICK_CYC, 1'b1);
    wr(CTRL_B_OFS, 32'h88);
    wr(CTRL_B_OFS, 32'hA8);
    repeat (1000) @(posedge pclk);
    #1;
    chk(lct_active, 1'b1);
    wr(CTRL_A_OFS, 32'h4);
    chk(lct_active, 1'b0);
    $display("Test length done");
    // Pending maintenance taken on reaching OFF; bypass from control_a
    wr(CTRL_B_OFS, 32'h85);
    chk(cm_state, ST_BREAK);
    pulse(2);
    chk(cm_state, ST_OFF);
    @(posedge pclk);
    #1;
    chk(cm_state, ST_MAINT);
    wr(CTRL_A_OFS, 32'h2);
    chk(station_bypass, 1'b1);
    wr(CTRL_B_OFS, 32'h81);
    chk(cm_state, ST_BREAK);
    wr(CTRL_B_OFS, 32'h83);
    chk(cm_state, ST_OFF);
    $display("Test pending done");
    results();
  end
endmodule : tb_connection_mgmt_ctrl_bits
`default_nettype wire
